// >>> logic/usb_ind_pkg.sv
// Purpose: Shared constants and types for the indirect USB register port
// Assumes: Byte-wide core special-function register accesses
// Notes:   Internal register addresses are six bits wide
package usb_ind_pkg;

  // Special-function register addresses seen by the core
  localparam logic [7:0] SFR_IND_ADDR = 8'h96;
  localparam logic [7:0] SFR_IND_DATA = 8'h97;

  // Fields of the indirect address register, endpoint selector width and endpoint count
  localparam int         BUSY_BIT     = 7;
  localparam int         AUTO_READ_NEXT_BIT   = 6;
  localparam int         TGT_W        = 6;
  localparam int         EPSEL_W      = 4;
  localparam logic [3:0] EP_COUNT     = 4'h4;

  // Internal controller register map
  localparam logic [5:0] A_FUNCTION_ADDR_REG      = 6'h00;
  localparam logic [5:0] A_POWER      = 6'h01;
  localparam logic [5:0] A_IN_FLAGS   = 6'h02;
  localparam logic [5:0] A_OUT_FLAGS  = 6'h04;
  localparam logic [5:0] A_CM_FLAGS   = 6'h06;
  localparam logic [5:0] A_IN_EN      = 6'h07;
  localparam logic [5:0] A_OUT_EN     = 6'h09;
  localparam logic [5:0] A_CM_EN      = 6'h0b;
  localparam logic [5:0] A_FRAME_LO   = 6'h0c;
  localparam logic [5:0] A_FRAME_HI   = 6'h0d;
  localparam logic [5:0] A_INDEX      = 6'h0e;
  localparam logic [5:0] A_CLOCK_RECOVERY_CTRL     = 6'h0f;
  localparam logic [5:0] A_IN_CSR_LO  = 6'h11;
  localparam logic [5:0] A_IN_CSR_HI  = 6'h12;
  localparam logic [5:0] A_OUT_CSR_LO = 6'h14;
  localparam logic [5:0] A_OUT_CSR_HI = 6'h15;
  localparam logic [5:0] A_EP0_CNT    = 6'h16;
  localparam logic [5:0] A_OUT_CNT_HI = 6'h17;
  localparam logic [5:0] A_EP_ENABLE  = 6'h1e;

  // Reset values
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_CLOCK_RECOVERY_CTRL   = 8'h0f;

  // Indirect fetch sequencer, Gray along idle-fetch-load
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_LOAD  = 2'b11
  } fetch_state_t;

  // Source of a fetched byte
  typedef enum logic [1:0] {
    SRC_LOCAL  = 2'b00,
    SRC_COMMON = 2'b01,
    SRC_MEM    = 2'b10
  } fetch_src_t;

  // Internal register write request
  typedef struct packed {
    logic       en;
    logic [5:0] addr;
    logic [7:0] data;
  } ireg_wr_t;

  // Software-owned common registers
  typedef struct packed {
    logic [7:0] function_addr;
    logic [7:0] power_mgmt;
    logic [7:0] in_irq_en;
    logic [7:0] out_irq_en;
    logic [7:0] common_irq_en;
    logic [7:0] clock_recovery;
    logic [7:0] endpoint_enable;
  } common_regs_t;

  // Hardware event pulses that set interrupt flags
  typedef struct packed {
    logic [7:0] in_ep;
    logic [7:0] out_ep;
    logic [7:0] common;
  } irq_events_t;

  // True for an endpoint-indexed control/status byte
  function automatic logic is_csr(input logic [5:0] a);
    is_csr = (a == A_IN_CSR_LO) || (a == A_IN_CSR_HI) ||
             (a == A_OUT_CSR_LO) || (a == A_OUT_CSR_HI);
  endfunction

  // Slot of an indexed control/status byte within one endpoint
  function automatic logic [1:0] csr_slot(input logic [5:0] a);
    if (a == A_IN_CSR_LO) begin
      csr_slot = 2'h0;
    end else if (a == A_IN_CSR_HI) begin
      csr_slot = 2'h1;
    end else if (a == A_OUT_CSR_LO) begin
      csr_slot = 2'h2;
    end else begin
      csr_slot = 2'h3;
    end
  endfunction

endpackage

// >>> logic/ep_csr_mem.sv
// Purpose: Per-endpoint control/status bytes, four endpoints by four slots
// Assumes: One write and one read port on the core clock
// Notes:   Read data appear from a register one edge after the request
`timescale 1ns/1ns
module ep_csr_mem (
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  input  wire logic       wr_en_in,
  input  wire logic [3:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       rd_en_in,
  input  wire logic [3:0] rd_idx_in,
  output logic      [7:0] rd_data_out
);
  import usb_ind_pkg::*;

  logic [7:0] mem_q [16];
  logic [7:0] rd_q;

  // Storage, cleared by reset
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= RST_ZERO;
      end
    end else if (wr_en_in) begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
  end

  // Registered read port
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_q <= RST_ZERO;
    end else if (rd_en_in) begin
      rd_q <= mem_q[rd_idx_in];
    end
  end

  assign rd_data_out = rd_q;
endmodule

// >>> logic/common_reg_bank.sv
// Purpose: Software-owned common controller registers
// Assumes: Writes arrive as internal write requests
// Notes:   Unlisted addresses are ignored here
`timescale 1ns/1ns
module common_reg_bank (
  input  wire logic                      core_clk_in,
  input  wire logic                      srst_in,
  input  wire usb_ind_pkg::ireg_wr_t     wr_in,
  input  wire logic                      rd_en_in,
  input  wire logic [5:0]                rd_addr_in,
  output logic      [7:0]                rd_data_out,
  output usb_ind_pkg::common_regs_t      regs_out
);
  import usb_ind_pkg::*;

  common_regs_t regs_q;
  logic [7:0]   rd_q;

  // Register writes by internal address
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      regs_q                <= '0;
      regs_q.clock_recovery <= RST_CLOCK_RECOVERY_CTRL;
    end else if (wr_in.en) begin
      if (wr_in.addr == A_FUNCTION_ADDR_REG) begin
        regs_q.function_addr <= wr_in.data;
      end else if (wr_in.addr == A_POWER) begin
        regs_q.power_mgmt <= wr_in.data;
      end else if (wr_in.addr == A_IN_EN) begin
        regs_q.in_irq_en <= wr_in.data;
      end else if (wr_in.addr == A_OUT_EN) begin
        regs_q.out_irq_en <= wr_in.data;
      end else if (wr_in.addr == A_CM_EN) begin
        regs_q.common_irq_en <= wr_in.data;
      end else if (wr_in.addr == A_CLOCK_RECOVERY_CTRL) begin
        regs_q.clock_recovery <= wr_in.data;
      end else if (wr_in.addr == A_EP_ENABLE) begin
        regs_q.endpoint_enable <= wr_in.data;
      end
    end
  end

  // Registered read, zero for anything not held here
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_q <= RST_ZERO;
    end else if (rd_en_in) begin
      if (rd_addr_in == A_FUNCTION_ADDR_REG) begin
        rd_q <= regs_q.function_addr;
      end else if (rd_addr_in == A_POWER) begin
        rd_q <= regs_q.power_mgmt;
      end else if (rd_addr_in == A_IN_EN) begin
        rd_q <= regs_q.in_irq_en;
      end else if (rd_addr_in == A_OUT_EN) begin
        rd_q <= regs_q.out_irq_en;
      end else if (rd_addr_in == A_CM_EN) begin
        rd_q <= regs_q.common_irq_en;
      end else if (rd_addr_in == A_CLOCK_RECOVERY_CTRL) begin
        rd_q <= regs_q.clock_recovery;
      end else if (rd_addr_in == A_EP_ENABLE) begin
        rd_q <= regs_q.endpoint_enable;
      end else begin
        rd_q <= RST_ZERO;
      end
    end
  end

  assign rd_data_out = rd_q;
  assign regs_out    = regs_q;
endmodule

// >>> logic/usb_indirect_reg_access.sv
// Purpose: Indirect address/data port from the core into the USB registers
// Assumes: Core and USB logic share core_clk_in; strobes last one cycle
// Notes:   Core read data answer one edge after the read strobe
`timescale 1ns/1ns

// What this block does
// - Data register write is forwarded to the selected internal register.
// - Writing busy one starts a fetch; busy holds until data valid.
// - Address and read-start busy bit are accepted in one write.
// - With auto-read set, the device starts further reads itself.
// - Eight-bit read/write data register at 0x97, reset zero, sole path.
// - Interrupt flag registers decoded at 0x02, 0x04 and 0x06.
// - Interrupt enable registers decoded at 0x07, 0x09 and 0x0B.
// - Function address at 0x00, frame number bytes at 0x0C/0x0D.
// - Selector at 0x0E; IN/OUT status bytes routed to chosen endpoint.
// - Endpoint 0 byte count at 0x16, OUT count high at 0x17.
// - Busy one means data register invalid; zero means valid.
// - With auto-read set, each data register read while idle launches a fetch.
// - Four-bit selector picks endpoints 0 to 3; higher codes reserved.
module usb_indirect_reg_access (
  input  wire logic                      core_clk_in,
  input  wire logic                      srst_in,
  input  wire logic [7:0]                sfr_addr_in,
  input  wire logic                      sfr_wr_in,
  input  wire logic                      sfr_rd_in,
  input  wire logic [7:0]                sfr_wdata_in,
  input  wire usb_ind_pkg::irq_events_t  irq_events_in,
  input  wire logic [15:0]               frame_number_in,
  input  wire logic [7:0]                ep_zero_rx_count_in,
  input  wire logic [7:0]                ep_out_count_high_in,
  output logic      [7:0]                sfr_rdata_out,
  output logic      [3:0]                endpoint_select_out,
  output usb_ind_pkg::common_regs_t      common_regs_out,
  output usb_ind_pkg::irq_events_t       irq_flags_out,
  output usb_ind_pkg::ireg_wr_t          csr_wr_out
);
  import usb_ind_pkg::*;

  fetch_state_t          state_q;
  fetch_state_t          state_d;
  fetch_src_t            src_q;
  logic                  auto_read_next_q;
  logic [TGT_W-1:0]      target_reg_select_q;
  logic [7:0]            indirect_data_reg_q;
  logic [EPSEL_W-1:0]    endpoint_select_q;
  logic [7:0]            local_q;
  logic [7:0]            sfr_rdata_q;
  irq_events_t           flags_q;
  irq_events_t           flag_clr;
  ireg_wr_t              iwr;
  ireg_wr_t              csr_wr_q;
  logic                  busy;
  logic                  addr_wr;
  logic                  data_wr;
  logic                  data_rd;
  logic                  start_fetch;
  logic                  fetching;
  logic                  ep_ok;
  logic [3:0]            mem_idx;
  logic [7:0]            common_rd;
  logic [7:0]            mem_rd;
  logic [7:0]            local_val;

  // Core strobes decoded by special-function address
  assign addr_wr  = sfr_wr_in && (sfr_addr_in == SFR_IND_ADDR);
  assign data_wr  = sfr_wr_in && (sfr_addr_in == SFR_IND_DATA);
  assign data_rd  = sfr_rd_in && (sfr_addr_in == SFR_IND_DATA);
  assign fetching = (state_q == ST_FETCH);

  // Busy covers the whole fetch, so stale data is never flagged valid
  assign busy = (state_q != ST_IDLE);

  // Fetch starts from the busy bit or, in auto mode, a data read
  always_comb begin
    start_fetch = 1'b0;
    if (state_q == ST_IDLE) begin
      if (addr_wr && sfr_wdata_in[BUSY_BIT]) begin
        start_fetch = 1'b1;
      end else if (data_rd && auto_read_next_q) begin
        start_fetch = 1'b1;
      end
    end
  end

  // Selected endpoint must be one of the implemented ones
  assign ep_ok   = (endpoint_select_q < EP_COUNT);
  assign mem_idx = {endpoint_select_q[1:0], csr_slot(target_reg_select_q)};

  // Fetch sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_fetch) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        state_d = ST_LOAD;
      end
      ST_LOAD: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Address field and auto-read bit, one write may also start a fetch
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      target_reg_select_q <= '0;
      auto_read_next_q    <= 1'b0;
    end else if (addr_wr && !busy) begin
      target_reg_select_q <= sfr_wdata_in[TGT_W-1:0];
      auto_read_next_q    <= sfr_wdata_in[AUTO_READ_NEXT_BIT];
    end
  end

  // Internal write forwarded from a data register write while idle
  always_comb begin
    iwr      = '0;
    iwr.en   = data_wr && !busy;
    iwr.addr = target_reg_select_q;
    iwr.data = sfr_wdata_in;
  end

  // Endpoint selector, upper bits read back as zero
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      endpoint_select_q <= '0;
    end else if (iwr.en && (iwr.addr == A_INDEX)) begin
      endpoint_select_q <= iwr.data[EPSEL_W-1:0];
    end
  end

  // Indexed write strobe to the endpoint logic, one edge late; the status store takes it unregistered
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      csr_wr_q <= '0;
    end else begin
      csr_wr_q.en   <= iwr.en && is_csr(iwr.addr) && ep_ok;
      csr_wr_q.addr <= iwr.addr;
      csr_wr_q.data <= iwr.data;
    end
  end

  // Flags clear when fetched; a simultaneous event still sets
  always_comb begin
    flag_clr = '0;
    if (fetching) begin
      if (target_reg_select_q == A_IN_FLAGS) begin
        flag_clr.in_ep = '1;
      end else if (target_reg_select_q == A_OUT_FLAGS) begin
        flag_clr.out_ep = '1;
      end else if (target_reg_select_q == A_CM_FLAGS) begin
        flag_clr.common = '1;
      end
    end
  end

  // Sticky interrupt flags
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | irq_events_in;
    end
  end

  // Registers held in this module, zero for unlisted addresses
  always_comb begin
    if (target_reg_select_q == A_IN_FLAGS) begin
      local_val = flags_q.in_ep;
    end else if (target_reg_select_q == A_OUT_FLAGS) begin
      local_val = flags_q.out_ep;
    end else if (target_reg_select_q == A_CM_FLAGS) begin
      local_val = flags_q.common;
    end else if (target_reg_select_q == A_FRAME_LO) begin
      local_val = frame_number_in[7:0];
    end else if (target_reg_select_q == A_FRAME_HI) begin
      local_val = frame_number_in[15:8];
    end else if (target_reg_select_q == A_INDEX) begin
      local_val = {{(8-EPSEL_W){1'b0}}, endpoint_select_q};
    end else if (target_reg_select_q == A_EP0_CNT && ep_ok) begin
      local_val = ep_zero_rx_count_in;
    end else if (target_reg_select_q == A_OUT_CNT_HI && ep_ok) begin
      local_val = ep_out_count_high_in;
    end else begin
      local_val = RST_ZERO;
    end
  end

  // Capture local value and source at the fetch edge
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      local_q <= RST_ZERO;
      src_q   <= SRC_LOCAL;
    end else if (fetching) begin
      local_q <= local_val;
      if (is_csr(target_reg_select_q) && ep_ok) begin
        src_q <= SRC_MEM;
      end else if (local_val != RST_ZERO || !common_hit()) begin
        src_q <= SRC_LOCAL;
      end else begin
        src_q <= SRC_COMMON;
      end
    end
  end

  // True when the common bank owns the current target address
  function automatic logic common_hit();
    common_hit = (target_reg_select_q == A_FUNCTION_ADDR_REG) ||
                 (target_reg_select_q == A_POWER) ||
                 (target_reg_select_q == A_IN_EN) ||
                 (target_reg_select_q == A_OUT_EN) ||
                 (target_reg_select_q == A_CM_EN) ||
                 (target_reg_select_q == A_CLOCK_RECOVERY_CTRL) ||
                 (target_reg_select_q == A_EP_ENABLE);
  endfunction

  // Data register: fetched byte, core write, otherwise held
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      indirect_data_reg_q <= RST_ZERO;
    end else if (state_q == ST_LOAD) begin
      case (src_q)
        SRC_COMMON: indirect_data_reg_q <= common_rd;
        SRC_MEM:    indirect_data_reg_q <= mem_rd;
        default:    indirect_data_reg_q <= local_q;
      endcase
    end else if (iwr.en) begin
      indirect_data_reg_q <= sfr_wdata_in;
    end
  end

  // Core read answer, one edge after the strobe
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sfr_rdata_q <= RST_ZERO;
    end else if (sfr_rd_in) begin
      if (sfr_addr_in == SFR_IND_ADDR) begin
        sfr_rdata_q <= {busy, auto_read_next_q, target_reg_select_q};
      end else if (sfr_addr_in == SFR_IND_DATA) begin
        sfr_rdata_q <= indirect_data_reg_q;
      end else begin
        sfr_rdata_q <= RST_ZERO;
      end
    end
  end

  // Software-owned common registers
  common_reg_bank u_common (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .wr_in       (iwr),
    .rd_en_in    (fetching),
    .rd_addr_in  (target_reg_select_q),
    .rd_data_out (common_rd),
    .regs_out    (common_regs_out)
  );

  // Per-endpoint control/status store
  ep_csr_mem u_csr (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .wr_en_in    (iwr.en && is_csr(iwr.addr) && ep_ok),
    .wr_idx_in   ({endpoint_select_q[1:0], csr_slot(iwr.addr)}),
    .wr_data_in  (iwr.data),
    .rd_en_in    (fetching),
    .rd_idx_in   (mem_idx),
    .rd_data_out (mem_rd)
  );

  // Outputs straight from registers
  assign sfr_rdata_out       = sfr_rdata_q;
  assign endpoint_select_out = endpoint_select_q;
  assign irq_flags_out       = flags_q;
  assign csr_wr_out          = csr_wr_q;
endmodule

// >>> sim/usb_ind_sva.sv
// Purpose: Concurrent checks on the indirect register port
// Assumes: One clock, synchronous active-high reset
// Notes:   Shadows the busy count and control field from core strobes
`timescale 1ns/1ns
module usb_ind_sva (
  input  wire logic                      core_clk_in,
  input  wire logic                      srst_in,
  input  wire logic [7:0]                sfr_addr_in,
  input  wire logic                      sfr_wr_in,
  input  wire logic                      sfr_rd_in,
  input  wire logic [7:0]                sfr_wdata_in,
  input  wire usb_ind_pkg::irq_events_t  irq_events_in,
  input  wire logic [15:0]               frame_number_in,
  input  wire logic [7:0]                ep_zero_rx_count_in,
  input  wire logic [7:0]                ep_out_count_high_in,
  input  wire logic [7:0]                sfr_rdata_out,
  input  wire logic [3:0]                endpoint_select_out,
  input  wire usb_ind_pkg::common_regs_t common_regs_out,
  input  wire usb_ind_pkg::irq_events_t  irq_flags_out,
  input  wire usb_ind_pkg::ireg_wr_t     csr_wr_out
);
  import usb_ind_pkg::*;
  logic [1:0] cnt_q;
  logic [6:0] ctl_q;
  logic       busy;
  logic       wr_ctl;
  logic       rd_dat;
  logic       wr_dat;
  logic       sel_wr;
  logic       start;
  // Strobe decode; writes during a fetch are dropped
  assign busy   = cnt_q != 2'h0;
  assign wr_ctl = sfr_wr_in && sfr_addr_in == SFR_IND_ADDR;
  assign rd_dat = sfr_rd_in && sfr_addr_in == SFR_IND_DATA;
  assign wr_dat = sfr_wr_in && sfr_addr_in == SFR_IND_DATA && !busy;
  assign sel_wr = wr_dat && ctl_q[5:0] == A_INDEX;
  assign start  = !busy && (wr_ctl && sfr_wdata_in[BUSY_BIT] ||
                            rd_dat && ctl_q[AUTO_READ_NEXT_BIT]);
  // Busy shadow of two cycles; control field taken only when idle
  always_ff @(posedge core_clk_in) begin
    cnt_q <= srst_in ? 2'h0 : start ? 2'h2 : busy ? cnt_q - 2'h1 : cnt_q;
    ctl_q <= srst_in ? 7'h00 : (wr_ctl && !busy) ? sfr_wdata_in[6:0] : ctl_q;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // Control poll and selector write steps
  sequence s_poll;
    sfr_rd_in && sfr_addr_in == SFR_IND_ADDR;
  endsequence
  sequence s_sel_wr;
    sel_wr;
  endsequence
  busy_flag_a: assert property (
    s_poll |=> sfr_rdata_out[7] == $past(busy))
    else $error("busy flag does not match fetch state");
  ctl_field_a: assert property (
    s_poll |=> sfr_rdata_out[6:0] == $past(ctl_q))
    else $error("control field readback wrong");
  data_hold_a: assert property (
    !sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data moved without a read");
  other_sfr_a: assert property (
    sfr_rd_in && sfr_addr_in != SFR_IND_ADDR &&
    sfr_addr_in != SFR_IND_DATA |=> sfr_rdata_out == 8'h00)
    else $error("foreign address read not zero");
  csr_fwd_a: assert property (
    csr_wr_out.en |-> $past(wr_dat) && csr_wr_out.addr == 6'($past(ctl_q))
      && csr_wr_out.data == $past(sfr_wdata_in))
    else $error("indexed write not from data write");
  csr_sel_a: assert property (
    csr_wr_out.en |-> endpoint_select_out < EP_COUNT)
    else $error("indexed write with reserved selector");
  sel_write_a: assert property (
    s_sel_wr |=> endpoint_select_out == 4'($past(sfr_wdata_in)))
    else $error("selector not loaded");
  sel_hold_a: assert property (
    !sel_wr |=> $stable(endpoint_select_out))
    else $error("selector changed unprompted");
  flag_set_a: assert property (
    |irq_events_in |=>
      (irq_flags_out & $past(irq_events_in)) == $past(irq_events_in))
    else $error("event did not set its flag");
  flag_clr_a: assert property (
    |($past(irq_flags_out) & ~irq_flags_out) |-> $past(busy) || $past(start))
    else $error("flag cleared outside a fetch");
endmodule

// >>> sim/core_sfr_model.sv
// Purpose: Processor-core model for special-function reads and writes
// Assumes: Strobes launched 1 ns after a rising edge, one cycle each
// Notes:   Released address and data lines show the inverse value
`timescale 1ns/1ns
module core_sfr_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] sfr_rdata_in,
  output logic      [7:0] sfr_addr_out,
  output logic            sfr_wr_out,
  output logic            sfr_rd_out,
  output logic      [7:0] sfr_wdata_out
);
  import usb_ind_pkg::*;
  // Quiet bus at time zero
  initial begin
    {sfr_addr_out, sfr_wr_out, sfr_rd_out, sfr_wdata_out} = 18'h00000;
  end
  // One strobe cycle; answer taken at the following edge
  task automatic access(input logic wr, input logic [7:0] a, d,
                        output logic [7:0] q);
    @(posedge core_clk_in);
    #1;
    sfr_addr_out = a;
    sfr_wdata_out = d;
    sfr_wr_out = wr;
    sfr_rd_out = !wr;
    @(posedge core_clk_in);
    #1;
    {sfr_wr_out, sfr_rd_out} = 2'b00;
    sfr_addr_out = ~a;
    sfr_wdata_out = ~d;
    q = sfr_rdata_in;
  endtask
  // Poll the busy flag, bounded
  task automatic wait_idle();
    logic [7:0] q;
    for (int i = 0; i < 16; i++) begin
      access(1'b0, SFR_IND_ADDR, 8'h00, q);
      if (!q[BUSY_BIT]) begin
        return;
      end
    end
    $display("BAD busy_poll expected 00 seen %h", q);
    usb_indirect_reg_access_tb.error_cnt++;
  endtask
  // Address then data; data write repeats need no reload
  task automatic ind_write(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wait_idle();
    access(1'b1, SFR_IND_ADDR, {2'b00, a}, q);
    access(1'b1, SFR_IND_DATA, d, q);
  endtask
  // Address and start in one write, poll, then fetch the byte
  task automatic ind_read(input logic [5:0] a, output logic [7:0] q);
    wait_idle();
    access(1'b1, SFR_IND_ADDR, {2'b10, a}, q);
    wait_idle();
    access(1'b0, SFR_IND_DATA, 8'h00, q);
  endtask
endmodule

// >>> sim/usb_indirect_reg_access_tb.sv
// Purpose: Self-checking bench for the indirect register port
// Assumes: All special-function traffic comes from the core model
// Notes:   Checker is bound to the design below the bench module
`timescale 1ns/1ns
module usb_indirect_reg_access_tb;
  import usb_ind_pkg::*;
  logic         core_clk_in;
  logic         srst_in;
  logic [7:0]   sfr_addr_in;
  logic         sfr_wr_in;
  logic         sfr_rd_in;
  logic [7:0]   sfr_wdata_in;
  irq_events_t  irq_events_in;
  logic [15:0]  frame_number_in;
  logic [7:0]   ep_zero_rx_count_in;
  logic [7:0]   ep_out_count_high_in;
  logic [7:0]   sfr_rdata_out;
  logic [3:0]   endpoint_select_out;
  common_regs_t common_regs_out;
  irq_events_t  irq_flags_out;
  ireg_wr_t     csr_wr_out;
  logic [7:0]   q;
  int           error_cnt;
  int           n_tests;
  // 25 MHz clock
  initial core_clk_in = 1'b0;
  always #20 core_clk_in = ~core_clk_in;
  usb_indirect_reg_access DUT (.*);
  core_sfr_model core (
    .core_clk_in   (core_clk_in),
    .sfr_rdata_in  (sfr_rdata_out),
    .sfr_addr_out  (sfr_addr_in),
    .sfr_wr_out    (sfr_wr_in),
    .sfr_rd_out    (sfr_rd_in),
    .sfr_wdata_out (sfr_wdata_in)
  );
  // Byte comparison with running counts
  task automatic chk8(input string nm, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Indirect fetch of an internal register
  task automatic rchk(input string nm, input logic [5:0] a, logic [7:0] e);
    core.ind_read(a, q);
    chk8(nm, e, q);
  endtask
  // Direct special-function read
  task automatic schk(input string nm, input logic [7:0] a, logic [7:0] e);
    core.access(1'b0, a, 8'h00, q);
    chk8(nm, e, q);
  endtask
  // Counts and verdict
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Reset values, then a repeated data read keeps the byte
  task automatic t_reset();
    schk("ctl_reset", SFR_IND_ADDR, 8'h00);
    schk("data_reset", SFR_IND_DATA, 8'h00);
    rchk("clock_recovery_ctrl_reset", A_CLOCK_RECOVERY_CTRL, RST_CLOCK_RECOVERY_CTRL);
    schk("data_retain", SFR_IND_DATA, RST_CLOCK_RECOVERY_CTRL);
  endtask
  // Read/write common registers, then a write without reload
  task automatic t_common();
    logic [5:0] rw [7] = '{A_FUNCTION_ADDR_REG, A_POWER, A_IN_EN, A_OUT_EN, A_CM_EN,
                           A_CLOCK_RECOVERY_CTRL, A_EP_ENABLE};
    foreach (rw[i]) core.ind_write(rw[i], 8'h30 + 8'(i));
    foreach (rw[i]) rchk("rw_reg", rw[i], 8'h30 + 8'(i));
    chk8("function_addr_reg_out", 8'h30, common_regs_out.function_addr);
    core.access(1'b1, SFR_IND_DATA, 8'h6e, q);
    rchk("repeat_wr", A_EP_ENABLE, 8'h6e);
    chk8("ep_en_out", 8'h6e, common_regs_out.endpoint_enable);
  endtask
  // Read-only bytes come from the inputs
  task automatic t_inputs();
    frame_number_in = 16'hc3a5;
    ep_zero_rx_count_in = 8'h41;
    ep_out_count_high_in = 8'h02;
    core.ind_write(A_FRAME_LO, 8'h00);
    rchk("frame_lo", A_FRAME_LO, 8'ha5);
    rchk("frame_hi", A_FRAME_HI, 8'hc3);
    rchk("ep0_count", A_EP0_CNT, 8'h41);
    rchk("out_cnt_hi", A_OUT_CNT_HI, 8'h02);
  endtask
  // Event pulses set flags; a fetch clears only its own flags
  task automatic t_flags();
    @(posedge core_clk_in);
    #1;
    irq_events_in = '{in_ep: 8'h81, out_ep: 8'h0e, common: 8'h24};
    @(posedge core_clk_in);
    #1;
    irq_events_in = '0;
    chk8("in_flag_out", 8'h81, irq_flags_out.in_ep);
    rchk("in_flags", A_IN_FLAGS, 8'h81);
    chk8("in_flag_clr", 8'h00, irq_flags_out.in_ep);
    chk8("out_flag_kept", 8'h0e, irq_flags_out.out_ep);
    rchk("out_flags", A_OUT_FLAGS, 8'h0e);
    rchk("cm_flags", A_CM_FLAGS, 8'h24);
    rchk("cm_en_kept", A_CM_EN, 8'h34);
  endtask
  // Selector routes indexed bytes; reserved codes block them
  task automatic t_index();
    core.ind_write(A_INDEX, 8'hf2);
    rchk("index_rd", A_INDEX, 8'h02);
    chk8("sel_out", 8'h02, {4'h0, endpoint_select_out});
    core.ind_write(A_IN_CSR_LO, 8'h3c);
    chk8("csr_en", 8'h01, {7'h00, csr_wr_out.en});
    chk8("csr_data", 8'h3c, csr_wr_out.data);
    core.ind_write(A_INDEX, 8'h01);
    rchk("csr_ep1", A_IN_CSR_LO, 8'h00);
    core.ind_write(A_INDEX, 8'h02);
    rchk("csr_ep2", A_IN_CSR_LO, 8'h3c);
    core.ind_write(A_INDEX, 8'h05);
    core.ind_write(A_OUT_CSR_LO, 8'h77);
    chk8("rsv_en", 8'h00, {7'h00, csr_wr_out.en});
    rchk("rsv_rd", A_OUT_CSR_LO, 8'h00);
  endtask
  // Busy during a fetch, then auto-read launches further fetches
  task automatic t_busy_auto();
    core.access(1'b1, SFR_IND_ADDR, 8'h8c, q);
    schk("busy_set", SFR_IND_ADDR, 8'h8c);
    schk("busy_clr", SFR_IND_ADDR, 8'h0c);
    schk("fetched", SFR_IND_DATA, 8'ha5);
    core.access(1'b1, SFR_IND_ADDR, 8'hcc, q);
    core.wait_idle();
    frame_number_in = 16'hc35a;
    schk("auto_old", SFR_IND_DATA, 8'ha5);
    schk("auto_busy", SFR_IND_ADDR, 8'hcc);
    core.wait_idle();
    schk("auto_next", SFR_IND_DATA, 8'h5a);
    core.wait_idle();
    core.access(1'b1, SFR_IND_ADDR, 8'h00, q);
  endtask
  // Unmapped targets and foreign addresses
  task automatic t_unmapped();
    core.ind_write(6'h20, 8'h3c);
    schk("data_wr_kept", SFR_IND_DATA, 8'h3c);
    rchk("unmapped", 6'h20, 8'h00);
    rchk("gap_reg", 6'h03, 8'h00);
    schk("sfr_other", 8'h55, 8'h00);
  endtask
  // Main sequence
  initial begin
    error_cnt = 0;
    n_tests = 0;
    srst_in = 1'b1;
    irq_events_in = '0;
    frame_number_in = 16'h0000;
    ep_zero_rx_count_in = 8'h00;
    ep_out_count_high_in = 8'h00;
    repeat (4) @(posedge core_clk_in);
    #1;
    srst_in = 1'b0;
    t_reset();
    t_common();
    t_inputs();
    t_flags();
    t_index();
    t_busy_auto();
    t_unmapped();
    conclude();
  end
  // Watchdog well past the expected run
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule
bind usb_indirect_reg_access usb_ind_sva chk (.*);
